// ===== verilog/acs_device.sv
`timescale 1ns/1ps
`default_nettype none
module acs_device #(
  parameter int unsigned STEP_CYCLES = acs_pkg::SAR_STEP_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  acs_link_if.dev link,
  input wire logic [acs_pkg::RES_BITS-1:0] analog_level,
  output logic hold,
  output logic [acs_pkg::GAIN_W-1:0] amp_gain,
  output logic amp_settling,
  output logic settle_start
);
  import acs_pkg::*;

  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [3:0] TOP_BIT = 4'(RES_BITS - 1);

  acs_dev_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0] bit_idx_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic [GAIN_CODE_W-1:0] gain_s1_r;
  logic [GAIN_CODE_W-1:0] gain_s2_r;
  logic [GAIN_CODE_W-1:0] gain_code_r;
  logic [RES_BITS-1:0] level_s1_r;
  logic [RES_BITS-1:0] level_s2_r;
  logic [RES_BITS-1:0] held_r;
  logic [RES_BITS-1:0] sar_r;
  logic [RES_BITS-1:0] sar_nxt;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] data_r;
  logic status_r;
  logic [CNT_W-1:0] settle_cnt_r;
  logic cs_rise;
  logic cs_fall;
  logic step_end;

  // budget includes pin synchroniser latency
  if (STEP_CYCLES < 1 ||
      int'(APERTURE_CYC) + RES_BITS * STEP_CYCLES + int'(DATA_SETUP_CYC) + SYNC_LAT_CYC > int'(CONV_MAX_CYC))
  begin : g_chk
    $error("step length breaks the conversion time budget");
  end
  if (SYNC_LAT_CYC > int'(GAIN_SW_CYC))
  begin : g_chk_gain
    $error("gain response slower than allowed");
  end

  assign link.status = status_r;
  assign link.data = data_r;

  // pins from the host pass two flops before any logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_s1_r <= 1'b0;
      cs_s2_r <= 1'b0;
      cs_s3_r <= 1'b0;
      gain_s1_r <= GC_X1;
      gain_s2_r <= GC_X1;
      level_s1_r <= '0;
      level_s2_r <= '0;
    end
    else
    begin
      cs_s1_r <= link.conv_start;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      gain_s1_r <= {link.gain_select_bit_hi, link.gain_select_bit_lo};
      gain_s2_r <= gain_s1_r;
      level_s1_r <= analog_level;
      level_s2_r <= level_s1_r;
    end
  end

  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign cs_fall = ~cs_s2_r & cs_s3_r;
  assign step_end = (state_r == DEV_CONVERT) && (cnt_r == '0);

  // one trial bit per step, kept if it does not overshoot the held level
  always_comb
  begin
    trial = sar_r | (RES_BITS'(1) << bit_idx_r);
    sar_nxt = (trial <= held_r) ? trial : sar_r;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= DEV_IDLE;
      cnt_r <= '0;
      bit_idx_r <= '0;
    end
    else
    begin
      case (state_r)
        DEV_IDLE:
          // a start edge during a conversion does not restart it, but its rise still clears sar_r
          if (cs_fall)
          begin
            cnt_r <= APERTURE_CYC - 1'b1;
            state_r <= DEV_APERTURE;
          end
        DEV_APERTURE:
          if (cnt_r == '0)
          begin
            cnt_r <= STEP_LAST;
            bit_idx_r <= TOP_BIT;
            state_r <= DEV_CONVERT;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        DEV_CONVERT:
          if (cnt_r == '0)
          begin
            if (bit_idx_r == '0)
            begin
              cnt_r <= DATA_SETUP_CYC - 1'b1;
              state_r <= DEV_PRESENT;
            end
            else
            begin
              bit_idx_r <= bit_idx_r - 1'b1;
              cnt_r <= STEP_LAST;
            end
          end
          else
            cnt_r <= cnt_r - 1'b1;
        DEV_PRESENT:
          if (cnt_r == '0)
            state_r <= DEV_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        default:
          state_r <= DEV_IDLE;
      endcase
    end
  end

  // approximation register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sar_r <= '0;
    else if (cs_rise)
      sar_r <= '0;
    else if (step_end)
      sar_r <= sar_nxt;
  end

  // track-and-hold and status move together
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold <= 1'b0;
      status_r <= 1'b0;
      held_r <= '0;
    end
    else if (state_r == DEV_APERTURE && cnt_r == '0)
    begin
      hold <= 1'b1;
      status_r <= 1'b1;
      held_r <= level_s2_r;
    end
    else if (state_r == DEV_PRESENT && cnt_r == '0)
    begin
      hold <= 1'b0;
      status_r <= 1'b0;
    end
  end

  // loaded a setup period before status falls, then left alone
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      data_r <= DATA_RST;
    else if (step_end && bit_idx_r == '0)
      data_r <= ~sar_nxt;
  end

  // gain front end; overlaps a running conversion on purpose
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gain_code_r <= GC_X1;
      amp_gain <= GAIN_X1;
      settle_start <= 1'b0;
      settle_cnt_r <= '0;
      amp_settling <= 1'b0;
    end
    else
    begin
      settle_start <= 1'b0;
      if (gain_s2_r != gain_code_r)
      begin
        gain_code_r <= gain_s2_r;
        settle_start <= 1'b1;
        settle_cnt_r <= acs_settle_cyc(gain_s2_r);
        amp_settling <= 1'b1;
        case (gain_s2_r)
          GC_X1: amp_gain <= GAIN_X1;
          GC_X10: amp_gain <= GAIN_X10;
          GC_X100: amp_gain <= GAIN_X100;
          default: amp_gain <= GAIN_X500;
        endcase
      end
      else if (settle_cnt_r != '0)
      begin
        settle_cnt_r <= settle_cnt_r - 1'b1;
        amp_settling <= (settle_cnt_r != CNT_W'(1));
      end
    end
  end
endmodule // acs_device
`default_nettype wire

// ===== verilog/acs_pkg.sv
`default_nettype none
package acs_pkg;
  localparam int unsigned RES_BITS = 12;
  localparam int unsigned GAIN_CODE_W = 2;
  localparam int unsigned GAIN_W = 9;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned SYNC_LAT_CYC = 3;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_APERTURE_NS = 230;
  localparam int unsigned T_CONV_MAX_NS = 15000;
  localparam int unsigned T_DATA_SETUP_NS = 15;
  localparam int unsigned T_GAIN_SW_NS = 2000;
  localparam int unsigned T_ACQ_NS = 3000;
  localparam int unsigned T_CS_WIDTH_NS = 50;
  localparam int unsigned T_SETTLE_LO_NS = 10000;
  localparam int unsigned T_SETTLE_100_NS = 15000;
  localparam int unsigned T_SETTLE_500_NS = 50000;
  localparam int unsigned T_CYCLE_500_NS = 50000;
  // least times round up, longest times round down
  localparam logic [CNT_W-1:0] APERTURE_CYC = CNT_W'((T_APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV_MAX_CYC = CNT_W'(T_CONV_MAX_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DATA_SETUP_CYC = CNT_W'((T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GAIN_SW_CYC = CNT_W'(T_GAIN_SW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACQ_CYC = CNT_W'((T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CS_WIDTH_CYC = CNT_W'((T_CS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETTLE_LO_CYC = CNT_W'(T_SETTLE_LO_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETTLE_100_CYC = CNT_W'(T_SETTLE_100_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETTLE_500_CYC = CNT_W'(T_SETTLE_500_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYCLE_500_CYC = CNT_W'(T_CYCLE_500_NS / CLK_PERIOD_NS);
  localparam int unsigned SAR_STEP_CYC =
    (int'(CONV_MAX_CYC) - int'(APERTURE_CYC) - int'(DATA_SETUP_CYC) - SYNC_LAT_CYC) / RES_BITS;
  localparam logic [GAIN_CODE_W-1:0] GC_X1 = 2'h0;
  localparam logic [GAIN_CODE_W-1:0] GC_X10 = 2'h1;
  localparam logic [GAIN_CODE_W-1:0] GC_X100 = 2'h2;
  localparam logic [GAIN_CODE_W-1:0] GC_X500 = 2'h3;
  localparam logic [GAIN_W-1:0] GAIN_X1 = 9'h001;
  localparam logic [GAIN_W-1:0] GAIN_X10 = 9'h00a;
  localparam logic [GAIN_W-1:0] GAIN_X100 = 9'h064;
  localparam logic [GAIN_W-1:0] GAIN_X500 = 9'h1f4;
  localparam logic [RES_BITS-1:0] DATA_RST = 12'h000;

  typedef enum {DEV_IDLE, DEV_APERTURE, DEV_CONVERT, DEV_PRESENT} acs_dev_state_t;
  typedef enum {HST_IDLE, HST_PULSE, HST_WAIT_BUSY, HST_WAIT_DONE, HST_ACQ} acs_host_state_t;

  function automatic logic [CNT_W-1:0] acs_settle_cyc(input logic [GAIN_CODE_W-1:0] code);
    logic [CNT_W-1:0] r;
    r = SETTLE_LO_CYC;
    if (code == GC_X100)
      r = SETTLE_100_CYC;
    else if (code == GC_X500)
      r = SETTLE_500_CYC;
    return r;
  endfunction
endpackage
`default_nettype wire

// ===== verilog/acs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acs_link_if;
  logic conv_start;
  logic gain_select_bit_hi;
  logic gain_select_bit_lo;
  logic status;
  logic [acs_pkg::RES_BITS-1:0] data;
  modport dev (input conv_start, input gain_select_bit_hi, input gain_select_bit_lo, output status, output data);
  modport host (output conv_start, output gain_select_bit_hi, output gain_select_bit_lo, input status, input data);
endinterface
`default_nettype wire

// ===== verilog/acs_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module acs_buf2 #(
  parameter int unsigned WIDTH = 12
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import acs_pkg::*;

  logic skid_valid_r;
  logic [WIDTH-1:0] skid_data_r;

  if (WIDTH < 1)
  begin : g_chk
    $error("acs_buf2 width must be at least one");
  end

  // full exactly when the spare entry is occupied
  assign in_ready = ~skid_valid_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid_r <= 1'b0;
      skid_data_r <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      if (skid_valid_r)
      begin
        out_data <= skid_data_r;
        out_valid <= 1'b1;
        skid_valid_r <= 1'b0;
      end
      else
      begin
        out_data <= in_data;
        out_valid <= in_valid;
      end
    end
    else if (in_valid && !skid_valid_r)
    begin
      skid_data_r <= in_data;
      skid_valid_r <= 1'b1;
    end
  end
endmodule // acs_buf2
`default_nettype wire

// ===== verilog/acs_host.sv
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  input wire logic clk,
  input wire logic reset_n,
  acs_link_if.host link,
  input wire logic run,
  input wire logic [acs_pkg::GAIN_CODE_W-1:0] gain_req,
  output logic [acs_pkg::RES_BITS-1:0] res_data,
  output logic res_valid,
  input wire logic res_ready,
  output logic conv_active
);
  import acs_pkg::*;

  acs_host_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] settle_r;
  logic status_s1_r;
  logic status_s2_r;
  logic [RES_BITS-1:0] data_s1_r;
  logic [RES_BITS-1:0] data_s2_r;
  logic cs_r;
  logic [GAIN_CODE_W-1:0] gain_r;
  logic push_r;
  logic [RES_BITS-1:0] push_data_r;
  logic buf_in_ready;

  if (SETTLE_500_CYC > CYCLE_500_CYC)
  begin : g_chk
    $error("gain 500 settling exceeds the cycle budget");
  end

  assign link.conv_start = cs_r;
  assign link.gain_select_bit_hi = gain_r[1];
  assign link.gain_select_bit_lo = gain_r[0];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_s1_r <= 1'b0;
      status_s2_r <= 1'b0;
      data_s1_r <= DATA_RST;
      data_s2_r <= DATA_RST;
    end
    else
    begin
      status_s1_r <= link.status;
      status_s2_r <= status_s1_r;
      data_s1_r <= link.data;
      data_s2_r <= data_s1_r;
    end
  end

  // settling of the last gain change must finish before the next start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      settle_r <= '0;
    else if (state_r == HST_PULSE && cnt_r == '0 && gain_req != gain_r)
      settle_r <= acs_settle_cyc(gain_req);
    else if (settle_r != '0)
      settle_r <= settle_r - 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= HST_IDLE;
      cnt_r <= '0;
      cs_r <= 1'b0;
      gain_r <= GC_X1;
      push_r <= 1'b0;
      push_data_r <= DATA_RST;
      conv_active <= 1'b0;
    end
    else
    begin
      push_r <= 1'b0;
      case (state_r)
        HST_IDLE:
          // no start while busy, and only with room for the word
          if (run && buf_in_ready && settle_r == '0 && !status_s2_r)
          begin
            cs_r <= 1'b1;
            cnt_r <= CS_WIDTH_CYC - 1'b1;
            conv_active <= 1'b1;
            state_r <= HST_PULSE;
          end
        HST_PULSE:
          if (cnt_r == '0)
          begin
            cs_r <= 1'b0;
            gain_r <= gain_req;
            state_r <= HST_WAIT_BUSY;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        HST_WAIT_BUSY:
          if (status_s2_r)
            state_r <= HST_WAIT_DONE;
        HST_WAIT_DONE:
          if (!status_s2_r)
          begin
            push_r <= 1'b1;
            push_data_r <= data_s2_r;
            cnt_r <= ACQ_CYC - 1'b1;
            state_r <= HST_ACQ;
          end
        HST_ACQ:
          if (cnt_r == '0)
          begin
            conv_active <= 1'b0;
            state_r <= HST_IDLE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        default:
          state_r <= HST_IDLE;
      endcase
    end
  end

  acs_buf2 #(
    .WIDTH(RES_BITS)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push_r),
    .in_ready(buf_in_ready),
    .in_data(push_data_r),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule // acs_host
`default_nettype wire

// ===== tb/acs_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acs_link_properties #(
  parameter int unsigned STEP_CYCLES = acs_pkg::SAR_STEP_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic gain_select_bit_hi,
  input wire logic gain_select_bit_lo,
  input wire logic status,
  input wire logic [acs_pkg::RES_BITS-1:0] data
);
  import acs_pkg::*;
  int hi_cnt_r;
  int gap_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // cycles of status high so far
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hi_cnt_r <= 0;
    else if (status)
      hi_cnt_r <= hi_cnt_r + 1;
    else
      hi_cnt_r <= 0;
  end

  // saturates so the first start after reset is not flagged
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gap_r <= 1000;
    else if (status)
      gap_r <= 0;
    else if (gap_r < 1000)
      gap_r <= gap_r + 1;
  end

  aperture_delay_a: assert property ($fell(conv_start) && !status |-> !status [*4] ##[1:8] status)
    else $error("status did not rise after the aperture delay");
  conv_time_a: assert property ($fell(conv_start) && !status |-> ##[1:300] $fell(status))
    else $error("conversion exceeded its time limit");
  status_width_a: assert property ($fell(status) |-> hi_cnt_r == int'(RES_BITS) * STEP_CYCLES + 1)
    else $error("status high for the wrong number of cycles");
  data_setup_a: assert property ($changed(data) |-> ##1 $fell(status))
    else $error("data not set up one cycle before status fell");
  data_hold_a: assert property ($changed(data) |-> status)
    else $error("data changed outside a conversion");
  no_restart_a: assert property ($fell(conv_start) |-> !status)
    else $error("start issued while converting");
  acq_gap_a: assert property ($rose(conv_start) |-> gap_r >= int'(ACQ_CYC))
    else $error("acquisition time too short");
  gain_move_a: assert property ($changed({gain_select_bit_hi, gain_select_bit_lo}) |-> $fell(conv_start))
    else $error("gain changed away from a start edge");

  cover property ($fell(status));
  cover property ($changed({gain_select_bit_hi, gain_select_bit_lo}));
  cover property ($rose(conv_start) && gap_r < 200);
endmodule // acs_link_properties
`default_nettype wire

// ===== tb/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
  import acs_pkg::*;
  localparam int unsigned STEP = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic res_ready = 1'b0;
  logic [GAIN_CODE_W-1:0] gain_req = GC_X1;
  logic [RES_BITS-1:0] level = 12'h000;
  logic [RES_BITS-1:0] level_b = 12'h000;
  logic [RES_BITS-1:0] res_data;
  logic [RES_BITS-1:0] d0;
  logic res_valid, conv_active, hold, amp_settling, settle_start;
  logic [GAIN_W-1:0] amp_gain;
  int n_mismatch = 0;
  int tests_run = 0;
  int settle_n = 0;
  int hi_b = 0;
  longint t_prev = 0;
  longint t_last = 0;
  logic [GAIN_CODE_W-1:0] t_g [6] = '{GC_X10, GC_X100, GC_X500, GC_X500, GC_X500, GC_X1};
  logic [RES_BITS-1:0] t_lv [6] = '{12'h000, 12'hfff, 12'h5a3, 12'h001, 12'h800, 12'h7ff};
  logic [GAIN_W-1:0] t_eg [6] = '{GAIN_X10, GAIN_X100, GAIN_X500, GAIN_X500, GAIN_X500, GAIN_X1};
  logic t_st [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  always #25 clk = ~clk;

  acs_link_if link();
  acs_link_if link_b();

  acs_host u_acs_host (.clk(clk), .reset_n(reset_n), .link(link), .run(run), .gain_req(gain_req),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready), .conv_active(conv_active));
  acs_device #(.STEP_CYCLES(STEP)) u_acs_device (.clk(clk), .reset_n(reset_n), .link(link), .analog_level(level),
    .hold(hold), .amp_gain(amp_gain), .amp_settling(amp_settling), .settle_start(settle_start));
  // second device driven straight from the bench to break the start spacing
  acs_device #(.STEP_CYCLES(STEP)) u_acs_device_b (.clk(clk), .reset_n(reset_n), .link(link_b),
    .analog_level(level_b), .hold(), .amp_gain(), .amp_settling(), .settle_start());
  acs_link_properties #(.STEP_CYCLES(STEP)) u_acs_link_properties (.clk(clk), .reset_n(reset_n),
    .conv_start(link.conv_start), .gain_select_bit_hi(link.gain_select_bit_hi),
    .gain_select_bit_lo(link.gain_select_bit_lo), .status(link.status), .data(link.data));

  always @(posedge clk)
  begin
    if (settle_start === 1'b1)
      settle_n <= settle_n + 1;
    if (link_b.status === 1'b1)
      hi_b <= hi_b + 1;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait; reads values settled before the edge
  task automatic wait_high(ref logic s, input logic v);
    int i;
    i = 0;
    @(posedge clk);
    while (s !== v && i < 4000)
    begin
      @(posedge clk);
      i++;
    end
    check(16'(s), 16'(v));
  endtask

  task automatic pop(input logic [RES_BITS-1:0] e);
    wait_high(res_valid, 1'b1);
    check(res_data, e);
    res_ready <= 1'b1;
    @(posedge clk);
    res_ready <= 1'b0;
  endtask

  task automatic convert(input int k);
    logic [RES_BITS-1:0] e;
    e = ~t_lv[k];
    @(posedge clk);
    level <= t_lv[k];
    gain_req <= t_g[k];
    run <= 1'b1;
    wait_high(conv_active, 1'b1);
    t_prev = t_last;
    t_last = $time;
    run <= 1'b0;
    // the sampler must be seen in hold, not only back in tracking
    wait_high(hold, 1'b1);
    wait_high(res_valid, 1'b1);
    check(link.data, e);
    check({link.gain_select_bit_hi, link.gain_select_bit_lo}, t_g[k]);
    check(amp_gain, t_eg[k]);
    check(amp_settling, t_st[k]);
    check(hold, 1'b0);
    pop(e);
    wait_high(conv_active, 1'b0);
  endtask

  task automatic pulse_b;
    @(posedge clk);
    link_b.conv_start <= 1'b1;
    @(posedge clk);
    link_b.conv_start <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    link_b.conv_start = 1'b0;
    link_b.gain_select_bit_hi = 1'b0;
    link_b.gain_select_bit_lo = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      convert(k);
      if (k == 4)
        check(16'(t_last - t_prev <= 1000 * CLK_PERIOD_NS), 16'h0001);
    end
    check(16'(settle_n), 16'h0004);
    $display("test gain table done");
    // stall the reader until both buffer entries are full
    @(posedge clk);
    level <= 12'h3c3;
    run <= 1'b1;
    wait_high(res_valid, 1'b1);
    wait_high(conv_active, 1'b1);
    wait_high(conv_active, 1'b0);
    repeat (2 * ACQ_CYC) @(posedge clk);
    check(conv_active, 1'b0);
    run <= 1'b0;
    pop(12'hc3c);
    pop(12'hc3c);
    @(posedge clk);
    check(res_valid, 1'b0);
    $display("test buffer fill done");
    level_b <= 12'h2b4;
    pulse_b();
    wait_high(link_b.status, 1'b1);
    pulse_b();
    wait_high(link_b.status, 1'b0);
    // acquisition spacing before the clean restart
    repeat (ACQ_CYC) @(posedge clk);
    d0 = link_b.data;
    level_b <= 12'h0f0;
    pulse_b();
    wait_high(link_b.status, 1'b1);
    check(link_b.data, d0);
    wait_high(link_b.status, 1'b0);
    @(posedge clk);
    check(link_b.data, 12'hf0f);
    check(16'(hi_b), 16'(2 * (12 * STEP + 1)));
    $display("test early start done");
    print_verdict();
  end
endmodule // adc_conversion_sequencer_bench
`default_nettype wire
